/* File: shared/hsov_pkg.sv */
// package for the high-speed status overlay block: register map, fields, reset values
//
// Functional notes
// - outgoing link-ok field x0 passes signal, 01 forces low, 11 forces high.
// - incoming link-ok field x0 passes signal, 01 forces low, 11 forces high.
// - both force fields reset to 00; outgoing at 15:14, incoming at 13:12.
// - mask bit 7 clear lets loss of signal break channel sync status.
// - mask bit 7 set keeps signal loss out of sync status; resets to one.
// - reserved bit 6 always reads zero.
// - reserved bits 11:8 reset to 0011; software should preserve them.
// - bit 5 routes loss of block lock onto the alarm pin.
// - bit 4 routes invalid code word errors onto the alarm pin.
// - bit 3 routes gain control unlock onto the alarm pin.
// - bit 2 routes auto-zero calibration pending onto the alarm pin.
// - bit 1 routes PLL lock loss onto the alarm pin.
// - bit 0 routes receiver loss of signal onto the alarm pin.
// - enable bits 5:0 reset to zero so nothing reaches the alarm.
// - register 0x0009 of management device 0x1e, reset value 0x0380.
package hsov_pkg;

   // ----------------------------------------------------------------
   // register address
   // ----------------------------------------------------------------
   localparam logic [4:0] DEV_ADDR = 5'h1e;
   localparam logic [15:0] REG_ADDR = 16'h0009;
   localparam logic [15:0] REG_RESET = 16'h0380;
   localparam logic [15:0] RD_MASK = 16'hffbf;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int OUT_FORCE_LSB = 14;
   localparam int IN_FORCE_LSB = 12;
   localparam int SYNC_EXCL_BIT = 7;
   localparam int ALARM_EN_LSB = 0;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic block_lock_loss;
      logic bad_codeword;
      logic gain_unlock;
      logic autozero_pending;
      logic pll_unlock;
      logic signal_loss;
   } hsov_cond_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] dev;
      logic [15:0] addr;
      logic [15:0] wdata;
   } hsov_req_t;

endpackage : hsov_pkg

/* File: design/hsov_overlay.sv */
// high-speed status overlay: control register, alarm merge and link-ok forcing
`timescale 1ns/10ps
module hsov_overlay (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   // management register access
   input wire hsov_pkg::hsov_req_t REQ,
   output logic [15:0] RDATA,
   output logic RVALID,
   // receive conditions
   input wire hsov_pkg::hsov_cond_t COND,
   input wire logic CH_SYNC_RAW,
   output logic CH_SYNC_STATUS,
   output logic LOSS_ALARM_PIN,
   // low-speed link ok
   input wire logic LOWSIDE_LINK_OK_OUTPUT_RAW,
   output logic LOWSIDE_LINK_OK_OUTPUT,
   input wire logic LOWSIDE_LINK_OK_INPUT,
   output logic LOWSIDE_LINK_OK_INPUT_SEEN
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic force_apply(input logic [1:0] f, input logic v);
      force_apply = f[0] ? f[1] : v;
   endfunction : force_apply

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   logic [15:0] ctrl_ff;
   logic [15:0] nxt_ctrl;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic rvalid_ff;
   logic nxt_rvalid;
   logic hit;

   always_comb begin
      hit = (REQ.dev == hsov_pkg::DEV_ADDR) && (REQ.addr == hsov_pkg::REG_ADDR);
      nxt_ctrl = ctrl_ff;
      if (REQ.wr && hit) begin
         nxt_ctrl = REQ.wdata & hsov_pkg::RD_MASK;
      end
      nxt_rvalid = REQ.rd && !REQ.wr;
      nxt_rdata = rdata_ff;
      if (REQ.rd && !REQ.wr) begin
         nxt_rdata = hit ? (ctrl_ff & hsov_pkg::RD_MASK) : 16'h0000;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl_ff <= hsov_pkg::REG_RESET;
         rdata_ff <= 16'h0000;
         rvalid_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   // ----------------------------------------------------------------
   // status outputs
   // ----------------------------------------------------------------
   logic alarm_ff;
   logic nxt_alarm;
   logic sync_ff;
   logic nxt_sync;
   logic out_ok_ff;
   logic nxt_out_ok;
   logic in_ok_ff;
   logic nxt_in_ok;
   logic [5:0] en;

   always_comb begin
      en = ctrl_ff[hsov_pkg::ALARM_EN_LSB +: 6];
      nxt_alarm = |(en & COND);
      nxt_sync = CH_SYNC_RAW && (ctrl_ff[hsov_pkg::SYNC_EXCL_BIT] || !COND.signal_loss);
      nxt_out_ok = force_apply(ctrl_ff[hsov_pkg::OUT_FORCE_LSB +: 2], LOWSIDE_LINK_OK_OUTPUT_RAW);
      nxt_in_ok = force_apply(ctrl_ff[hsov_pkg::IN_FORCE_LSB +: 2], LOWSIDE_LINK_OK_INPUT);
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         alarm_ff <= 1'b0;
         sync_ff <= 1'b0;
         out_ok_ff <= 1'b0;
         in_ok_ff <= 1'b0;
      end else begin
         alarm_ff <= nxt_alarm;
         sync_ff <= nxt_sync;
         out_ok_ff <= nxt_out_ok;
         in_ok_ff <= nxt_in_ok;
      end
   end

   assign RDATA = rdata_ff;
   assign RVALID = rvalid_ff;
   assign LOSS_ALARM_PIN = alarm_ff;
   assign CH_SYNC_STATUS = sync_ff;
   assign LOWSIDE_LINK_OK_OUTPUT = out_ok_ff;
   assign LOWSIDE_LINK_OK_INPUT_SEEN = in_ok_ff;

endmodule : hsov_overlay

/* File: test/hsov_overlay_properties.sv */
// checker for the high-speed status overlay ports
`timescale 1ns/10ps
module hsov_overlay_properties (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   // register access
   input wire hsov_pkg::hsov_req_t REQ,
   input wire logic [15:0] RDATA,
   input wire logic RVALID,
   // receive status
   input wire hsov_pkg::hsov_cond_t COND,
   input wire logic CH_SYNC_RAW,
   input wire logic CH_SYNC_STATUS,
   input wire logic LOSS_ALARM_PIN
);
   default clocking dcb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   a_read_answer: assert property (REQ.rd && !REQ.wr |=> RVALID) else $error("no rvalid");
   a_bit6_clear: assert property (RVALID |-> !RDATA[6]) else $error("bit 6 set");
   a_write_back: assert property (REQ.wr && REQ.dev == hsov_pkg::DEV_ADDR && REQ.addr == hsov_pkg::REG_ADDR
      ##1 !REQ.wr ##1 REQ.rd && !REQ.wr |=> RDATA == ($past(REQ.wdata, 3) & hsov_pkg::RD_MASK))
      else $error("readback wrong");
   a_bad_addr: assert property (REQ.rd && !REQ.wr && REQ.addr != hsov_pkg::REG_ADDR |=> RDATA == 16'h0000)
      else $error("unmapped read");
   a_alarm_cause: assert property (LOSS_ALARM_PIN |-> $past(COND) != '0) else $error("alarm no cause");
   a_quiet_alarm: assert property (COND == '0 |=> !LOSS_ALARM_PIN) else $error("alarm stuck");
   a_sync_loss: assert property (!CH_SYNC_RAW |=> !CH_SYNC_STATUS) else $error("sync high");
   a_sync_keep: assert property (CH_SYNC_RAW && !COND.signal_loss |=> CH_SYNC_STATUS) else $error("sync low");
endmodule : hsov_overlay_properties
bind hsov_overlay hsov_overlay_properties hsov_overlay_properties_inst (.CLK_SYS, .RESET_N, .REQ, .RDATA,
   .RVALID, .COND, .CH_SYNC_RAW, .CH_SYNC_STATUS, .LOSS_ALARM_PIN);

/* File: test/hsov_far_end.sv */
// board monitor that samples the loss alarm pin
`timescale 1ns/10ps
module hsov_far_end (
   // pin side
   input wire logic clk,
   input wire logic alarm,
   output logic seen_ff
);
   always_ff @(posedge clk) seen_ff <= alarm;
endmodule : hsov_far_end

/* File: test/hsov_overlay_tb_top.sv */
// bench for the high-speed status overlay
`timescale 1ns/10ps
module hsov_overlay_tb_top;
   logic clk = 0, rst_n = 0, cs = 0, lo = 0, li = 0, rv, al, so, ro, ri, fs;
   logic [15:0] rd;
   hsov_pkg::hsov_req_t rq = '0;
   hsov_pkg::hsov_cond_t cd = '0;
   int n_mismatch = 0, samples_checked = 0;
   // control word, conditions, sync/out/in levels, expected alarm/sync/out/in
   logic [28:0] rows [6] = '{
      {16'h0301, 6'h01, 3'b111, 4'b1011},
      {16'h4380, 6'h01, 3'b110, 4'b0100},
      {16'hf33e, 6'h3e, 3'b100, 4'b1111},
      {16'h131e, 6'h20, 3'b011, 4'b0010},
      {16'h8320, 6'h20, 3'b101, 4'b1101},
      {16'h0302, 6'h3d, 3'b111, 4'b0011}};
   hsov_overlay hsov_overlay_inst (.CLK_SYS(clk), .RESET_N(rst_n), .REQ(rq), .RDATA(rd), .RVALID(rv), .COND(cd),
      .CH_SYNC_RAW(cs), .CH_SYNC_STATUS(so), .LOSS_ALARM_PIN(al), .LOWSIDE_LINK_OK_OUTPUT_RAW(lo),
      .LOWSIDE_LINK_OK_OUTPUT(ro), .LOWSIDE_LINK_OK_INPUT(li), .LOWSIDE_LINK_OK_INPUT_SEEN(ri));
   hsov_far_end hsov_far_end_inst (.clk(clk), .alarm(al), .seen_ff(fs));
   always #5 clk = ~clk;
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(logic [15:0] d);
      @(posedge clk);
      rq <= '{1'b1, 1'b0, hsov_pkg::DEV_ADDR, hsov_pkg::REG_ADDR, d};
      @(posedge clk);
      rq <= '0;
   endtask : wr
   task automatic rdchk(logic [15:0] a, logic [15:0] e);
      @(posedge clk);
      rq <= '{1'b0, 1'b1, hsov_pkg::DEV_ADDR, a, 16'h0000};
      @(posedge clk);
      rq <= '0;
      #1;
      chk("rvalid", 16'h0001, {15'h0000, rv});
      chk("rdata", e, rd);
   endtask : rdchk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      logic [28:0] r;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      cd <= '1;
      rdchk(hsov_pkg::REG_ADDR, 16'h0380);
      chk("alarm", 16'h0000, {15'h0000, al});
      foreach (rows[i]) begin
         r = rows[i];
         wr(r[28:13]);
         cd <= r[12:7];
         {cs, lo, li} <= r[6:4];
         @(posedge clk);
         #1;
         chk("alarm", {15'h0000, r[3]}, {15'h0000, al});
         chk("sync", {15'h0000, r[2]}, {15'h0000, so});
         chk("out", {15'h0000, r[1]}, {15'h0000, ro});
         chk("in", {15'h0000, r[0]}, {15'h0000, ri});
         @(posedge clk);
         #1;
         chk("far alarm", {15'h0000, r[3]}, {15'h0000, fs});
      end
      wr(16'hf3ff);
      rdchk(hsov_pkg::REG_ADDR, 16'hf3bf);
      rdchk(16'h000a, 16'h0000);
      // mid-run reset: register and outputs go back to defaults
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      #1;
      chk("alarm in reset", 16'h0000, {15'h0000, al});
      @(posedge clk);
      rst_n <= 1'b1;
      rdchk(hsov_pkg::REG_ADDR, 16'h0380);
      // write and read together: write only, no read answer; wrong address ignored
      @(posedge clk);
      rq <= '{1'b1, 1'b1, hsov_pkg::DEV_ADDR, 16'h000a, 16'hffff};
      @(posedge clk);
      rq <= '0;
      #1;
      chk("rvalid wr+rd", 16'h0000, {15'h0000, rv});
      rdchk(hsov_pkg::REG_ADDR, 16'h0380);
      report_and_stop();
   end
endmodule : hsov_overlay_tb_top
